//--- verilog/pfm_port_mux.sv
// Port pin function multiplexer with AXI4-Lite register access.
// Assumes asynchronous pads, peripherals on clk_i, one AXI master.

`timescale 1ns/10ps
`default_nettype none

module pfm_port_mux (
   // Clock and reset
   input  wire logic                      clk_i,
   input  wire logic                      arst_n_i,
   // AXI4-Lite write address and data
   input  wire logic [pfm_pkg::PFM_AW-1:0] s_axi_awaddr_i,
   input  wire logic                      s_axi_awvalid_i,
   output logic                           s_axi_awready_o,
   input  wire logic [31:0]               s_axi_wdata_i,
   input  wire logic [3:0]                s_axi_wstrb_i,
   input  wire logic                      s_axi_wvalid_i,
   output logic                           s_axi_wready_o,
   // AXI4-Lite write response
   output logic [1:0]                     s_axi_bresp_o,
   output logic                           s_axi_bvalid_o,
   input  wire logic                      s_axi_bready_i,
   // AXI4-Lite read
   input  wire logic [pfm_pkg::PFM_AW-1:0] s_axi_araddr_i,
   input  wire logic                      s_axi_arvalid_i,
   output logic                           s_axi_arready_o,
   output logic [31:0]                    s_axi_rdata_o,
   output logic [1:0]                     s_axi_rresp_o,
   output logic                           s_axi_rvalid_o,
   input  wire logic                      s_axi_rready_i,
   // Pads
   input  wire pfm_pkg::pfm_bank_t        pad_i,
   output pfm_pkg::pfm_pad_drv_t          pad_drv_o,
   output logic [3:0][7:0]                pullup_en_o,
   // Peripheral side
   input  wire pfm_pkg::pfm_bank_t        alt_out_i,
   output pfm_pkg::pfm_bank_t             pin_level_o,
   output logic [3:0]                     ext_irq_req_o,
   output logic                           capture_trig_o,
   output logic                           timer16_count_in_o,
   output logic                           timer8a_count_in_o,
   output logic                           timer8b_count_in_o,
   output logic [7:0]                     analog_in_lines_o
);

   import pfm_pkg::*;

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   pfm_bank_t    latch;
   pfm_bank_t    dir_in;
   pfm_bank_t    alt_sel;
   logic [3:0]   pullup_option;
   logic [5:0]   edge_sel;
   logic [3:0]   evt_flag;
   logic         aw_got;
   logic         w_got;
   logic [PFM_AW-1:0] waddr;
   logic [7:0]   wbyte;
   logic         wbyte_en;
   logic         wr_en;
   pfm_dec_t     wdec;
   pfm_dec_t     rdec;
   logic [7:0]   read_om;
   pfm_pad_drv_t next_drv;
   logic [3:0][7:0] next_pullup;
   logic [3:0]   irq_pulse;
   logic [3:0]   rise_en;
   logic [3:0]   fall_en;

   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   pfm_sync2 #(
      .WIDTH (PFM_NPORT*8)
   ) u_sync (
      .clk_i    (clk_i),
      .arst_n_i (arst_n_i),
      .async_i  (pad_i),
      .sync_o   (pin_level_o)
   );

   // ----------------------------------------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------------------------------------
   assign s_axi_awready_o = ~aw_got;
   assign s_axi_wready_o  = ~w_got;
   assign wr_en           = aw_got & w_got & ~s_axi_bvalid_o;
   assign wdec            = pfm_decode(waddr);

   // active-low asynchronous reset of all state.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         aw_got   <= 1'b0;
         w_got    <= 1'b0;
         waddr    <= '0;
         wbyte    <= 8'h00;
         wbyte_en <= 1'b0;
      end else begin
         if (s_axi_awvalid_i && !aw_got) begin
            aw_got <= 1'b1;
            waddr  <= s_axi_awaddr_i;
         end else if (wr_en) begin
            aw_got <= 1'b0;
         end
         if (s_axi_wvalid_i && !w_got) begin
            w_got    <= 1'b1;
            wbyte    <= s_axi_wdata_i[7:0];
            wbyte_en <= s_axi_wstrb_i[0];
         end else if (wr_en) begin
            w_got <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o  <= PFM_RESP_OKAY;
      end else if (wr_en) begin
         s_axi_bvalid_o <= 1'b1;
         s_axi_bresp_o  <= (wdec.kind == PFM_K_NONE) ? PFM_RESP_ERR
                                                     : PFM_RESP_OKAY;
      end else if (s_axi_bready_i) begin
         s_axi_bvalid_o <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Port registers
   // ----------------------------------------------------------------------
   // output latch holds written values for output-capable bits.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         latch <= PFM_LATCH_RST;
      end else if (wr_en && wbyte_en && wdec.kind == PFM_K_DATA) begin
         latch[wdec.idx] <= wbyte &
            (PFM_DIR_MASK[wdec.idx] | PFM_OUT_ONLY[wdec.idx]);
      end
   end

   // direction bits exist only where a bit can turn around.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         dir_in <= PFM_DIR_RST;
      end else if (wr_en && wbyte_en && wdec.kind == PFM_K_DIR) begin
         dir_in[wdec.idx] <= wbyte & PFM_DIR_MASK[wdec.idx];
      end
   end

   // alternate function chosen bit by bit.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         alt_sel <= PFM_ALT_RST;
      end else if (wr_en && wbyte_en && wdec.kind == PFM_K_ALT) begin
         alt_sel[wdec.idx] <= wbyte & PFM_ALT_MASK[wdec.idx];
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pullup_option <= PFM_PUO_RST;
         edge_sel      <= PFM_EDGE_RST;
      end else if (wr_en && wbyte_en) begin
         if (wdec.kind == PFM_K_PUO) pullup_option <= wbyte[3:0];
         if (wdec.kind == PFM_K_EDGE) edge_sel <= wbyte[5:0];
      end
   end

   // Event flags are write-one-to-clear; a new event beats the clear.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         evt_flag <= PFM_FLAG_RST;
      end else if (wr_en && wbyte_en && wdec.kind == PFM_K_FLAG) begin
         evt_flag <= (evt_flag & ~wbyte[3:0]) | irq_pulse;
      end else begin
         evt_flag <= evt_flag | irq_pulse;
      end
   end

   // ----------------------------------------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------------------------------------
   assign s_axi_arready_o = ~s_axi_rvalid_o;
   assign rdec            = pfm_decode(s_axi_araddr_i);
   assign read_om         = (PFM_DIR_MASK[rdec.idx] & ~dir_in[rdec.idx]) |
                            PFM_OUT_ONLY[rdec.idx];

   // output bits read their latch, input bits the synchronised pin.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o  <= 32'h0000_0000;
         s_axi_rresp_o  <= PFM_RESP_OKAY;
      end else if (s_axi_arvalid_i && !s_axi_rvalid_o) begin
         s_axi_rvalid_o <= 1'b1;
         s_axi_rresp_o  <= PFM_RESP_OKAY;
         s_axi_rdata_o  <= 32'h0000_0000;
         unique case (rdec.kind)
            PFM_K_DATA: s_axi_rdata_o[7:0] <= PFM_VALID_MASK[rdec.idx] &
               ((read_om & latch[rdec.idx]) |
                (~read_om & pin_level_o[rdec.idx]));
            PFM_K_DIR:  s_axi_rdata_o[7:0] <= dir_in[rdec.idx];
            PFM_K_ALT:  s_axi_rdata_o[7:0] <= alt_sel[rdec.idx];
            PFM_K_PUO:  s_axi_rdata_o[3:0] <= pullup_option;
            PFM_K_EDGE: s_axi_rdata_o[5:0] <= edge_sel;
            PFM_K_FLAG: s_axi_rdata_o[3:0] <= evt_flag;
            PFM_K_NONE: s_axi_rresp_o      <= PFM_RESP_ERR;
         endcase
      end else if (s_axi_rready_i) begin
         s_axi_rvalid_o <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Pad drive and pull-ups
   // ----------------------------------------------------------------------
   always_comb begin
      logic om;
      logic val;
      om       = 1'b0;
      val      = 1'b0;
      next_drv = '0;
      next_pullup = '0;
      for (int p = 0; p < PFM_NPORT; p++) begin
         for (int b = 0; b < 8; b++) begin
            // bits without a direction bit and not output-only
            // never leave input mode.
            om  = (PFM_DIR_MASK[p][b] & ~dir_in[p][b]) |
                  PFM_OUT_ONLY[p][b];
            val = alt_sel[p][b] ? alt_out_i[p][b] : latch[p][b];
            if (p >= PFM_FIRST_PCH) begin
               // ports 8 to 12 drive latch or display data.
               // same for the second output-only port.
               // alternate display drive overrides the direction.
               // high-side only, released when the value is low.
               next_drv.o[p][b]  = PFM_VALID_MASK[p][b];
               next_drv.oe[p][b] = PFM_VALID_MASK[p][b] &
                                   (om | alt_sel[p][b]) & val;
            end else if (p == PFM_P7) begin
               // pull low only, released when the latch is high.
               next_drv.o[p][b]  = 1'b0;
               next_drv.oe[p][b] = PFM_VALID_MASK[p][b] & om & ~val;
            end else begin
               // serial alternates drive through the direction bits.
               // host has set direction and latch for serial use.
               // timer and clock alternates follow the same path.
               next_drv.o[p][b]  = PFM_VALID_MASK[p][b] & val;
               next_drv.oe[p][b] = PFM_VALID_MASK[p][b] & om &
                  ~(alt_sel[p][b] & (p <= PFM_P1));
               // pull-up only on input port bits with option set.
               next_pullup[p][b] = PFM_VALID_MASK[p][b] & ~om &
                  ~alt_sel[p][b] & pullup_option[p];
            end
         end
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pad_drv_o   <= '0;
         pullup_en_o <= '0;
      end else begin
         pad_drv_o   <= next_drv;
         pullup_en_o <= next_pullup;
      end
   end

   // ----------------------------------------------------------------------
   // Alternate inputs to peripherals
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         timer16_count_in_o <= 1'b0;
         timer8a_count_in_o <= 1'b0;
         timer8b_count_in_o <= 1'b0;
         analog_in_lines_o  <= 8'h00;
      end else begin
         // port 0 bit 0 feeds the 16-bit timer count clock.
         timer16_count_in_o <= alt_sel[PFM_P0][PFM_T16_BIT] &
                               pin_level_o[PFM_P0][PFM_T16_BIT];
         // port 3 bits 3 and 4 feed the 8-bit timer count clocks.
         timer8a_count_in_o <= alt_sel[PFM_P3][PFM_T8A_BIT] &
                               pin_level_o[PFM_P3][PFM_T8A_BIT];
         timer8b_count_in_o <= alt_sel[PFM_P3][PFM_T8B_BIT] &
                               pin_level_o[PFM_P3][PFM_T8B_BIT];
         analog_in_lines_o  <= alt_sel[PFM_P1];
      end
   end

   // selectable edges on inputs 0 to 2.
   // input 3 fixed to falling edge.
   always_comb begin
      for (int k = 0; k < PFM_NIRQ; k++) begin
         if (k == PFM_NIRQ - 1) begin
            rise_en[k] = 1'b0;
            fall_en[k] = alt_sel[PFM_P0][k];
         end else begin
            rise_en[k] = alt_sel[PFM_P0][k] & edge_sel[2*k];
            fall_en[k] = alt_sel[PFM_P0][k] & edge_sel[2*k+1];
         end
      end
   end

   for (genvar k = 0; k < PFM_NIRQ; k++) begin : g_irq
      pfm_edge u_edge (
         .clk_i     (clk_i),
         .arst_n_i  (arst_n_i),
         .level_i   (pin_level_o[PFM_P0][k]),
         .rise_en_i (rise_en[k]),
         .fall_en_i (fall_en[k]),
         .pulse_o   (irq_pulse[k])
      );
   end

   assign ext_irq_req_o  = irq_pulse;
   // interrupt 0 edge doubles as capture trigger.
   assign capture_trig_o = irq_pulse[0];

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);

   p0_input_only_a: assert property (
      !pad_drv_o.oe[PFM_P0][0] && !pad_drv_o.oe[PFM_P0][4])
      else $error("port 0 input-only bit driven");

   p0_direction_a: assert property (
      pad_drv_o.oe[PFM_P0][1] ==
         $past(!dir_in[PFM_P0][1] && !alt_sel[PFM_P0][1]))
      else $error("port 0 bit 1 drive disagrees with direction");

   pullup_gate_a: assert property (
      pullup_en_o[2][5] |-> $past(dir_in[2][5] && pullup_option[2] &&
                                  !alt_sel[2][5]))
      else $error("pull-up active outside input port mode");

   irq_rise_a: assert property (
      ($rose(pin_level_o[PFM_P0][1]) && edge_sel[2] &&
       alt_sel[PFM_P0][1]) |=> ext_irq_req_o[1])
      else $error("rising edge on interrupt 1 missed");

   capture_pair_a: assert property (
      capture_trig_o == ext_irq_req_o[0])
      else $error("capture trigger not tied to interrupt 0");

   irq3_fall_a: assert property (
      ext_irq_req_o[3] |-> ($past(pin_level_o[PFM_P0][3], 2) &&
                            !$past(pin_level_o[PFM_P0][3])))
      else $error("interrupt 3 fired without a falling edge");

   t16_clock_a: assert property (
      timer16_count_in_o |-> $past(alt_sel[PFM_P0][PFM_T16_BIT]))
      else $error("timer count clock passed without alternate mode");

   analog_pullup_a: assert property (
      (analog_in_lines_o & pullup_en_o[PFM_P1]) == 8'h00)
      else $error("pull-up on an analog input");

   p7_pull_low_a: assert property (
      pad_drv_o.o[PFM_P7] == 8'h00)
      else $error("port 7 drives high");

   pch_high_a: assert property (
      &(pad_drv_o.o[PFM_NPORT-1:PFM_FIRST_PCH] |
        ~pad_drv_o.oe[PFM_NPORT-1:PFM_FIRST_PCH]))
      else $error("display port drives low");

   cov_irq_both: cover property (
      edge_sel[1:0] == 2'h3 ##1 ext_irq_req_o[0] ##[1:50] ext_irq_req_o[0]);
   cov_analog: cover property (analog_in_lines_o != 8'h00);
   cov_display: cover property (
      alt_sel[PFM_FIRST_PCH] != 8'h00 ##1 pad_drv_o.oe[PFM_FIRST_PCH] != 0);

endmodule

`default_nettype wire

//--- verilog/pfm_pkg.sv
// Package for the per-pin port function multiplexer.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses below 256.

`default_nettype none

package pfm_pkg;

   // ----------------------------------------------------------------------
   // Geometry
   // ----------------------------------------------------------------------
   // Bank index: 0..3 are ports 0..3, 4 is port 7, 5..9 are ports 8..12.
   localparam int PFM_NPORT     = 10;
   localparam int PFM_AW        = 8;
   localparam int PFM_P0        = 0;
   localparam int PFM_P1        = 1;
   localparam int PFM_P3        = 3;
   localparam int PFM_P7        = 4;
   localparam int PFM_FIRST_PCH = 5;
   localparam int PFM_NPULL     = 4;
   localparam int PFM_NIRQ      = 4;
   localparam int PFM_T16_BIT   = 0;
   localparam int PFM_T8A_BIT   = 3;
   localparam int PFM_T8B_BIT   = 4;

   typedef logic [PFM_NPORT-1:0][7:0] pfm_bank_t;

   typedef struct packed {
      pfm_bank_t o;
      pfm_bank_t oe;
   } pfm_pad_drv_t;

   typedef enum logic [2:0] {
      PFM_K_NONE, PFM_K_DATA, PFM_K_DIR, PFM_K_ALT,
      PFM_K_PUO, PFM_K_EDGE, PFM_K_FLAG
   } pfm_kind_t;

   typedef struct packed {
      pfm_kind_t   kind;
      logic [3:0]  idx;
   } pfm_dec_t;

   // ----------------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------------
   localparam logic [7:0] PFM_DATA_BASE = 8'h00;
   localparam logic [7:0] PFM_DIR_BASE  = 8'h40;
   localparam logic [7:0] PFM_ALT_BASE  = 8'h80;
   localparam logic [7:0] PFM_PUO_OFS   = 8'hC0;
   localparam logic [7:0] PFM_EDGE_OFS  = 8'hC4;
   localparam logic [7:0] PFM_FLAG_OFS  = 8'hC8;
   localparam logic [1:0] PFM_RESP_OKAY = 2'h0;
   localparam logic [1:0] PFM_RESP_ERR  = 2'h2;

   // Per-port bit masks, port 12 leftmost.
   localparam pfm_bank_t PFM_VALID_MASK = {8'hFF, 8'hFF, 8'hFF, 8'hFF,
      8'hFF, 8'h1F, 8'hFF, 8'hFF, 8'hFF, 8'h1F};
   localparam pfm_bank_t PFM_DIR_MASK   = {8'hFF, 8'hFF, 8'hFF, 8'h00,
      8'h00, 8'h1F, 8'hFF, 8'hFF, 8'hFF, 8'h0E};
   localparam pfm_bank_t PFM_OUT_ONLY   = {8'h00, 8'h00, 8'h00, 8'hFF,
      8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   localparam pfm_bank_t PFM_ALT_MASK   = {8'hFF, 8'hFF, 8'hFF, 8'hFF,
      8'hFF, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h1F};

   // ----------------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------------
   localparam pfm_bank_t  PFM_DIR_RST   = PFM_DIR_MASK;
   localparam pfm_bank_t  PFM_LATCH_RST = '0;
   localparam pfm_bank_t  PFM_ALT_RST   = '0;
   localparam logic [3:0] PFM_PUO_RST   = 4'h0;
   localparam logic [5:0] PFM_EDGE_RST  = 6'h00;
   localparam logic [3:0] PFM_FLAG_RST  = 4'h0;

   // Decodes a byte address into register kind and port index.
   function automatic pfm_dec_t pfm_decode(input logic [PFM_AW-1:0] a);
      pfm_dec_t d;
      d.kind = PFM_K_NONE;
      d.idx  = a[5:2];
      if (a[1:0] == 2'h0) begin
         if (a[5:2] < 4'(PFM_NPORT)) begin
            if (a[7:6] == PFM_DATA_BASE[7:6]) d.kind = PFM_K_DATA;
            else if (a[7:6] == PFM_DIR_BASE[7:6]) d.kind = PFM_K_DIR;
            else if (a[7:6] == PFM_ALT_BASE[7:6]) d.kind = PFM_K_ALT;
         end
         if (a == PFM_PUO_OFS) d.kind = PFM_K_PUO;
         else if (a == PFM_EDGE_OFS) d.kind = PFM_K_EDGE;
         else if (a == PFM_FLAG_OFS) d.kind = PFM_K_FLAG;
      end
      return d;
   endfunction

endpackage

`default_nettype wire

//--- verilog/pfm_sync2.sv
// Two-stage synchroniser for pin levels.
// Assumes inputs are asynchronous to clk_i.

`timescale 1ns/10ps
`default_nettype none

module pfm_sync2 #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             arst_n_i,
   // Levels
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta;

   // The first stage feeds only the second stage.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         meta   <= '0;
         sync_o <= '0;
      end else begin
         meta   <= async_i;
         sync_o <= meta;
      end
   end

endmodule

`default_nettype wire

//--- verilog/pfm_edge.sv
// Selectable edge detector producing a one-cycle registered pulse.
// Assumes a level already synchronised to clk_i.

`timescale 1ns/10ps
`default_nettype none

module pfm_edge (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic arst_n_i,
   // Level and edge enables
   input  wire logic level_i,
   input  wire logic rise_en_i,
   input  wire logic fall_en_i,
   // Event
   output logic      pulse_o
);

   logic prev;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         prev    <= 1'b0;
         pulse_o <= 1'b0;
      end else begin
         prev    <= level_i;
         pulse_o <= (rise_en_i & level_i & ~prev) |
                    (fall_en_i & ~level_i & prev);
      end
   end

endmodule

`default_nettype wire

//--- verification/pfm_board.sv
// Board model that resolves every pad from the block's drive and the board.
// Assumes the drive structs of pfm_pkg; undriven pads take the board level.
`timescale 1ns/10ps
`default_nettype none
module pfm_board (
   // Drive and board levels
   input  wire pfm_pkg::pfm_pad_drv_t drv_i,
   input  wire pfm_pkg::pfm_bank_t    brd_i,
   // Resolved pads
   output pfm_pkg::pfm_bank_t         pad_o
);
   import pfm_pkg::*;
   assign pad_o = (drv_i.o & drv_i.oe) | (brd_i & ~drv_i.oe);
endmodule
`default_nettype wire

//--- verification/pfm_port_mux_bench.sv
// Self-checking bench for the port pin function multiplexer.
// Assumes pfm_pkg, the design and the board model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module pfm_port_mux_bench;
   import pfm_pkg::*;
   logic            clk_i, arst_n_i, awv, wv, bry, arv, rry;
   logic            awr, wrd, bv, arr, rvl, cap, t16, t8a, t8b;
   logic [7:0]      aw, ar, d, ana;
   logic [31:0]     wd, rdat, rv;
   logic [1:0]      br, rr, rsp;
   logic [3:0]      irq;
   logic [3:0][7:0] pu;
   pfm_bank_t       brd, alt, pad, lvl;
   pfm_pad_drv_t    drv;
   int              err_count = 0, samples_checked = 0, caps = 0;
   int              seed, b, m;
   pfm_port_mux dut (.clk_i(clk_i), .arst_n_i(arst_n_i),
      .s_axi_awaddr_i(aw), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
      .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv),
      .s_axi_wready_o(wrd), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv),
      .s_axi_bready_i(bry), .s_axi_araddr_i(ar), .s_axi_arvalid_i(arv),
      .s_axi_arready_o(arr), .s_axi_rdata_o(rdat), .s_axi_rresp_o(rr),
      .s_axi_rvalid_o(rvl), .s_axi_rready_i(rry), .pad_i(pad),
      .pad_drv_o(drv), .pullup_en_o(pu), .alt_out_i(alt),
      .pin_level_o(lvl), .ext_irq_req_o(irq), .capture_trig_o(cap),
      .timer16_count_in_o(t16), .timer8a_count_in_o(t8a),
      .timer8b_count_in_o(t8b), .analog_in_lines_o(ana));
   pfm_board board (.drv_i(drv), .brd_i(brd), .pad_o(pad));
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) if (cap === 1'b1) caps <= caps + 1;
   function automatic logic [15:0] xp(int b, logic [7:0] d, l);
      logic [7:0] oe;
      oe = (~d & PFM_DIR_MASK[b]) | PFM_OUT_ONLY[b];
      if (b < 4) return {oe, l & oe};
      if (b == 4) return {oe & ~l, 8'h00};
      return {oe & l, oe & l};
   endfunction
   task chk(input logic [31:0] s, e);
      samples_checked++;
      if (s !== e) begin
         err_count++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task wr(input logic [7:0] a, v);
      int n;
      logic sa, sw, sb;
      n = 0;
      #1;
      aw <= a;
      wd <= {24'h0, v};
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b1;
      do begin
         @(negedge clk_i);
         sa = awr & awv;
         sw = wrd & wv;
         sb = bv;
         @(posedge clk_i);
         n++;
         if (sa) awv <= 1'b0;
         if (sw) wv <= 1'b0;
      end while (sb !== 1'b1 && n < 40);
      bry <= 1'b0;
      if (n >= 40) err_count++;
   endtask
   task rd(input logic [7:0] a);
      int n;
      logic sa, sb;
      n = 0;
      #1;
      ar <= a;
      arv <= 1'b1;
      rry <= 1'b1;
      do begin
         @(negedge clk_i);
         sa = arr & arv;
         sb = rvl;
         rv = rdat;
         rsp = rr;
         @(posedge clk_i);
         n++;
         if (sa) arv <= 1'b0;
      end while (sb !== 1'b1 && n < 40);
      rry <= 1'b0;
      if (n >= 40) err_count++;
   endtask
   task tick(input int k);
      repeat (k) @(posedge clk_i);
      #1;
   endtask
   task final_report;
      $display("checked %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #100000;
      err_count++;
      final_report;
   end
   initial begin
      seed = 86;
      {awv, wv, bry, arv, rry} = '0;
      {aw, ar, wd, brd} = '0;
      alt = pfm_bank_t'({$random(seed), $random(seed), $random(seed)});
      arst_n_i = 1'b0;
      repeat (2) @(posedge clk_i);
      arst_n_i <= 1'b1;
      rd(8'h40);
      chk(rv, 32'h0E);
      rd(8'hFC);
      chk(rsp, PFM_RESP_ERR);
      $display("reset test done");
      for (int i = 0; i < 14; i++) begin
         b = (i % 7 == 6) ? 9 : i % 7;
         d = 8'($random(seed));
         wr(8'(8'h40 + 4 * b), d);
         wr(8'(4 * b), 8'(i * 37 + 5));
         tick(2);
         chk({drv.oe[b], drv.o[b] & drv.oe[b]}, xp(b, d, 8'(i * 37 + 5)));
         rd(8'(8'h40 + 4 * b));
         chk(rv, d & PFM_DIR_MASK[b]);
         rd(8'(4 * b));
         chk(rv, ((~d & PFM_DIR_MASK[b]) | PFM_OUT_ONLY[b]) & PFM_VALID_MASK[b] & 8'(i * 37 + 5));
      end
      for (int k = 0; k < 4; k++) wr(8'(8'h40 + 4 * k), 8'hFF);
      $display("port drive test done");
      for (b = 5; b < 10; b++) begin
         wr(8'(8'h80 + 4 * b), 8'hFF);
         tick(2);
         chk({drv.oe[b], drv.o[b] | ~drv.oe[b]}, {alt[b], 8'hFF});
      end
      $display("display test done");
      wr(8'hC0, 8'h0F);
      wr(8'h48, 8'h0F);
      tick(2);
      chk({pu[2], pu[1]}, 16'h0FFF);
      d = 8'($random(seed));
      wr(8'h84, d);
      tick(2);
      chk({pu[1], ana}, {~d, d});
      $display("pullup test done");
      wr(8'h80, 8'h1F);
      wr(8'h8C, 8'h18);
      for (m = 1; m < 4; m++) begin
         wr(8'hC4, 8'(m | m << 2));
         brd[0] <= 8'h0B;
         brd[3] <= 8'($random(seed));
         tick(5);
         chk({t8b, t8a}, {brd[3][4], brd[3][3]});
         chk(t16, 1'b1);
         rd(8'hC8);
         chk(rv, (m & 1) * 3);
         wr(8'hC8, 8'h0F);
         brd[0] <= 8'h00;
         tick(5);
         rd(8'hC8);
         chk(rv, (m >> 1) * 3 + 8);
         wr(8'hC8, 8'h0F);
      end
      chk(caps, 4);
      $display("edge test done");
      final_report;
   end
endmodule
`default_nettype wire
